// ---- design/buck_fault_and_power_good_supervisor.sv ----
// fault handling, foldback and power-good supervision for four bucks
// assumes comparator levels in; options sit in a config register
//
// Summary of operation
// RULE1 - feedback below half target halves that channel's switching rate
// RULE2 - feedback below quarter target runs the channel at quarter rate
// RULE3 - at maximum duty every second pulse is dropped
// RULE4 - beyond maximum duty two of every three pulses are dropped
// RULE5 - peak limit turns high side off, low side on for the cycle
// RULE6 - each overcurrent event counts; overflow past 15 turns both gates off
// RULE7 - hiccup lasts seven soft-start periods, then a new soft start begins
// RULE8 - clean restart returns to normal, faulty one re-enters hiccup
// RULE9 - no overflow action during the first soft start after enable
// RULE10 - one option enables hiccup for all; foldback stays without it
// RULE11 - short-circuit latch-off after seven failed restarts in a row
// RULE12 - latched channel waits for enable low or supply lockout
// RULE13 - short-circuit latch-off does nothing while hiccup is disabled
// RULE14 - overvoltage latch-off option latches a channel at 124 percent
// RULE15 - supply lockout turns channel off; release soft starts if enabled
// RULE16 - lockout on channel one holds every other channel off
// RULE17 - good flag sets above 90.5 percent, clears after 50 us below 87.2
// RULE18 - power-good pin is the AND of selected good flags
// RULE19 - flags count after 1 ms high; any drop pulls the pin low at once
// RULE20 - selection of monitored channels is static; default is channel one
// RULE21 - over-temperature turns all channels off until it releases
// RULE22 - leaving over-temperature soft starts every enabled channel that is not latched off
// RULE23 - soft-start period per channel is 2, 4 or 8 ms
// RULE24 - comparator levels are synchronised before any logic uses them
// RULE25 - fault counter clears after a clean soft start or when disabled
`timescale 1ns/1ps
module buck_fault_and_power_good_supervisor import buck_sup_pkg::*; #(
    parameter int SS_CYC    = SS_BASE_CYC,
    parameter int VALID_CYC = PG_VALID_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire ana_t        ana_raw,
    input  wire bus_req_t    bus,
    output logic      [31:0] rd_data,
    output logic      [3:0]  hs_gate,
    output logic      [3:0]  ls_gate,
    output logic      [3:0]  soft_start_req,
    input  wire logic        power_good_in,
    output logic             power_good_out,
    output logic             power_good_oe
);

    // ********************
    // state and local constants
    // ********************
    typedef struct packed {
        ch_t [3:0]   ch;
        logic [31:0] cfg;
        logic [31:0] rd;
        logic        pg_oe;
        logic [2:0]  pg_pin;  // pin level, three-stage sampled
    } top_t;

    localparam logic [4:0]  PER_LAST = 5'(NOM_PER_CYC - 1);
    localparam logic [17:0] SS_BASE  = 18'(SS_CYC);

    top_t q, d;
    ana_t a;
    logic [3:0] good;
    logic [3:0] valid;

    // last soft-start count for a two-bit selection
    function automatic logic [17:0] ss_last(input logic [1:0] sel);
        logic [17:0] len;
        len = SS_BASE;
        case (sel)
            2'h0: len = SS_BASE;
            2'h1: len = SS_BASE << 1;
            default: len = SS_BASE << 2;
        endcase
        return len - 18'h00001;  // RULE23
    endfunction : ss_last

    // true for modes in which the stage switches
    function automatic logic switching(input ch_mode_t m);
        return (m == CH_SOFT) || (m == CH_RUN);
    endfunction : switching

    // ********************
    // input synchronisation and good flags
    // ********************
    // comparator levels cross into the clock domain first
    sync3 #(
        .W ($bits(ana_t))
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (ana_raw),
        .dout    (a)  // RULE24
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            good_filter #(
                .VALID_CYC (VALID_CYC)
            ) u_good (
                .ref_clk (ref_clk),
                .rst     (rst),
                .above   (a.good_above[g]),
                .below   (a.good_below[g]),
                .good    (good[g]),
                .valid   (valid[g])
            );
            assign hs_gate[g]        = q.ch[g].hs;
            assign ls_gate[g]        = q.ch[g].ls;
            assign soft_start_req[g] = q.ch[g].ss_req;
        end
    endgenerate

    // ********************
    // next state
    // ********************
    always_comb begin
        ch_t         c;
        ch_t         n;
        logic        hic_en;
        logic        scl_en;
        logic        ovl_en;
        logic        run_ok;
        logic        oc_ev;
        logic        ovf;
        logic        ss_end;
        logic        fail;
        logic [1:0]  fold_last;
        logic [1:0]  skip_last;
        logic [1:0]  sel;
        logic [17:0] last;
        logic [3:0]  pg_sel;
        c         = '0;
        n         = '0;
        oc_ev     = 1'b0;
        ovf       = 1'b0;
        ss_end    = 1'b0;
        fail      = 1'b0;
        fold_last = 2'h0;
        skip_last = 2'h0;
        sel       = 2'h0;
        last      = '0;
        run_ok    = 1'b0;
        d         = q;
        hic_en    = q.cfg[CFG_HIC_BIT];
        scl_en    = q.cfg[CFG_SCL_BIT] & hic_en;  // RULE13
        ovl_en    = q.cfg[CFG_OVL_BIT];
        pg_sel    = q.cfg[CFG_PGSEL_LSB +: 4];
        d.pg_pin  = {q.pg_pin[1:0], power_good_in};

        for (int i = 0; i < 4; i++) begin
            c    = q.ch[i];
            n    = c;
            sel  = q.cfg[CFG_SS_LSB + 2*i +: 2];
            last = ss_last(sel);
            // channel one lockout outranks the others; heat stops all
            run_ok = a.channel_enable_pin[i] && !a.supply_low_lockout[i]
                     && !((i != 0) && a.supply_low_lockout[0])  // RULE16
                     && !a.over_temp;                           // RULE21

            // pulse timing: one count per clock
            oc_ev = 1'b0;
            if (switching(c.mode)) begin
                // a peak while the high side conducts ends the pulse
                if (c.hs && (a.peak_limit[i] || a.pwm_end[i])) begin
                    n.hs = 1'b0;  // RULE5
                    n.ls = 1'b1;  // RULE5
                end
                if (c.hs && a.peak_limit[i] && !c.oc_hit) begin
                    oc_ev    = 1'b1;
                    n.oc_hit = 1'b1;
                end
                if (a.fb_quarter_low[i]) begin
                    fold_last = 2'h3;  // RULE2
                end else if (a.fb_half_low[i]) begin
                    fold_last = 2'h1;  // RULE1
                end else begin
                    fold_last = 2'h0;
                end
                if (a.duty_high[i]) begin
                    skip_last = 2'h2;  // RULE4
                end else if (a.max_duty[i]) begin
                    skip_last = 2'h1;  // RULE3
                end else begin
                    skip_last = 2'h0;
                end
                if (c.sw_cnt == PER_LAST) begin
                    n.sw_cnt = '0;
                    n.hs     = 1'b0;
                    n.ls     = 1'b1;
                    if (c.fold_cnt >= fold_last) begin
                        n.fold_cnt = '0;
                        if (c.skip_cnt >= skip_last) begin
                            n.skip_cnt = '0;
                            n.hs       = 1'b1;
                            n.ls       = 1'b0;
                            n.oc_hit   = 1'b0;
                        end else begin
                            n.skip_cnt = c.skip_cnt + 2'h1;  // RULE3
                        end
                    end else begin
                        n.fold_cnt = c.fold_cnt + 2'h1;  // RULE1
                    end
                end else begin
                    n.sw_cnt = c.sw_cnt + 5'h01;
                end
            end

            // counter saturates with hiccup off; foldback still acts
            ovf = oc_ev && (c.oc_cnt == OC_LIMIT) && hic_en;  // RULE10
            if (oc_ev && (c.oc_cnt != OC_LIMIT)) begin
                n.oc_cnt = c.oc_cnt + 4'h1;  // RULE6
            end
            ss_end = (c.ss_cnt == last);

            if (c.mode == CH_LATCH) begin
                // only a fresh enable or supply lockout frees it
                if (!a.channel_enable_pin[i] || a.supply_low_lockout[i]) begin
                    n.mode = CH_OFF;  // RULE12
                end
            end else if (!run_ok) begin
                n.mode   = CH_OFF;  // RULE15
                n.oc_cnt = '0;      // RULE25
                n.retry  = '0;
            end else begin
                case (c.mode)
                    CH_OFF: begin
                        n.mode     = CH_SOFT;  // RULE22
                        n.first_ss = 1'b1;     // RULE15
                        n.ss_cnt   = '0;
                        n.oc_seen  = 1'b0;
                        n.sw_cnt   = PER_LAST;
                    end
                    CH_SOFT: begin
                        n.ss_cnt  = c.ss_cnt + 18'h00001;
                        n.oc_seen = c.oc_seen | oc_ev;
                        // first start after enable never trips on overload
                        fail = !c.first_ss && hic_en  // RULE9
                               && (ovf || (ss_end && (c.oc_seen || oc_ev)));
                        if (ovl_en && a.ov_trip[i]) begin
                            n.mode = CH_LATCH;  // RULE14
                        end else if (fail) begin
                            if (scl_en && (c.retry == SC_RETRIES - 3'h1)) begin
                                n.mode = CH_LATCH;  // RULE11
                            end else begin
                                n.mode    = CH_HICCUP;  // RULE8
                                n.retry   = c.retry + 3'h1;
                                n.ss_cnt  = '0;
                                n.hic_cnt = '0;
                                n.oc_cnt  = '0;
                            end
                        end else if (ss_end) begin
                            n.mode     = CH_RUN;  // RULE8
                            n.first_ss = 1'b0;
                            n.oc_cnt   = '0;      // RULE25
                            n.retry    = '0;
                        end
                    end
                    CH_RUN: begin
                        if (ovl_en && a.ov_trip[i]) begin
                            n.mode = CH_LATCH;  // RULE14
                        end else if (ovf) begin
                            n.mode    = CH_HICCUP;  // RULE6
                            n.ss_cnt  = '0;
                            n.hic_cnt = '0;
                            n.oc_cnt  = '0;
                        end
                    end
                    CH_HICCUP: begin
                        // wait seven soft-start periods with both gates off
                        if (ss_end) begin
                            n.ss_cnt = '0;
                            if (c.hic_cnt == HICCUP_SS - 3'h1) begin
                                n.mode    = CH_SOFT;  // RULE7
                                n.oc_seen = 1'b0;
                                n.sw_cnt  = PER_LAST;
                            end else begin
                                n.hic_cnt = c.hic_cnt + 3'h1;  // RULE7
                            end
                        end else begin
                            n.ss_cnt = c.ss_cnt + 18'h00001;
                        end
                    end
                    default: begin
                        n.mode = CH_OFF;
                    end
                endcase
            end

            // outside switching modes the stage is fully off
            if (!switching(n.mode)) begin
                n.hs       = 1'b0;  // RULE6
                n.ls       = 1'b0;
                n.fold_cnt = '0;
                n.skip_cnt = '0;
                n.oc_hit   = 1'b0;
            end
            n.ss_req = (n.mode == CH_SOFT);
            d.ch[i]  = n;
        end

        // ********************
        // power-good pin
        // ********************
        // a dropped flag clears valid at once, so the pin falls next clock
        d.pg_oe = ~(&(valid | ~pg_sel));  // RULE18 RULE19 RULE20

        // ********************
        // register port
        // ********************
        d.rd = '0;
        if (bus.wr && (bus.addr == CFG_ADDR)) begin
            d.cfg = bus.wdata & CFG_MASK;  // RULE20
        end
        if (bus.rd) begin
            case (bus.addr)
                CFG_ADDR: d.rd = q.cfg;
                STAT_ADDR: begin
                    for (int i = 0; i < 4; i++) begin
                        d.rd[i]      = good[i];
                        d.rd[4 + i]  = (q.ch[i].mode == CH_LATCH);
                        d.rd[8 + i]  = (q.ch[i].mode == CH_HICCUP);
                        d.rd[12 + i] = (q.ch[i].mode == CH_RUN);
                    end
                    d.rd[16] = a.over_temp;
                    d.rd[17] = q.pg_pin[2];
                    d.rd[18] = a.supply_low_lockout[0];
                end
                default: d.rd = '0;  // unmapped reads return zero
            endcase
        end
    end

    // ********************
    // state register
    // ********************
    // reset: gates off, power-good pulled low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.cfg   <= CFG_RESET;
            q.pg_oe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // open drain: only ever drives low
    assign rd_data        = q.rd;
    assign power_good_oe  = q.pg_oe;
    assign power_good_out = 1'b0;

endmodule : buck_fault_and_power_good_supervisor

// ---- design/buck_sup_pkg.sv ----
// shared constants and types of the four-channel buck supervisor
// assumes one 20 MHz clock; analog comparator levels arrive unsynchronised
package buck_sup_pkg;

    // ********************
    // timing
    // ********************
    localparam int CLK_MHZ      = 20;
    localparam int CLK_NS       = 50;
    localparam int SS_BASE_US   = 2000;  // shortest soft-start period
    localparam int PG_VALID_US  = 1000;  // good flag must hold this long
    localparam int PG_FALL_NS   = 50000; // low output must persist this long
    localparam int SS_BASE_CYC  = SS_BASE_US * CLK_MHZ;
    localparam int PG_VALID_CYC = PG_VALID_US * CLK_MHZ;
    localparam int PG_FALL_CYC  = (PG_FALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int NOM_PER_CYC  = 20;    // nominal switching period

    // ********************
    // counts
    // ********************
    localparam logic [3:0] OC_LIMIT   = 4'hF;
    localparam logic [2:0] HICCUP_SS  = 3'h7;
    localparam logic [2:0] SC_RETRIES = 3'h7;

    // ********************
    // register map
    // ********************
    localparam logic [7:0]  CFG_ADDR      = 8'h00;
    localparam logic [7:0]  STAT_ADDR     = 8'h04;
    localparam int          CFG_HIC_BIT   = 0;
    localparam int          CFG_SCL_BIT   = 1;
    localparam int          CFG_OVL_BIT   = 2;
    localparam int          CFG_PGSEL_LSB = 4;
    localparam int          CFG_SS_LSB    = 8;
    localparam logic [31:0] CFG_MASK      = 32'h0000_FFF7;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0011;

    typedef enum logic [2:0] {CH_OFF, CH_SOFT, CH_RUN, CH_HICCUP, CH_LATCH} ch_mode_t;

    // comparator and pin levels from outside the clock domain
    typedef struct packed {
        logic [3:0] channel_enable_pin;
        logic [3:0] fb_half_low;     // feedback_sense below one half
        logic [3:0] fb_quarter_low;  // feedback_sense below one quarter
        logic [3:0] max_duty;
        logic [3:0] duty_high;
        logic [3:0] pwm_end;
        logic [3:0] peak_limit;      // overcurrent_protection threshold
        logic [3:0] ov_trip;         // output above 124 percent
        logic [3:0] good_above;      // output above 90.5 percent
        logic [3:0] good_below;      // output below 87.2 percent
        logic [3:0] supply_low_lockout;
        logic       over_temp;
    } ana_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        ch_mode_t    mode;
        logic        first_ss;
        logic        oc_seen;
        logic        oc_hit;
        logic [17:0] ss_cnt;
        logic [2:0]  hic_cnt;
        logic [2:0]  retry;
        logic [3:0]  oc_cnt;
        logic [4:0]  sw_cnt;
        logic [1:0]  fold_cnt;
        logic [1:0]  skip_cnt;
        logic        hs;
        logic        ls;
        logic        ss_req;
    } ch_t;

    typedef struct packed {
        logic        good;
        logic [9:0]  fall_cnt;
        logic [14:0] hold_cnt;
        logic        valid;
    } pgf_t;

endpackage : buck_sup_pkg

// ---- design/sync3.sv ----
// three-stage synchroniser for a bus of slow levels
// assumes each bit is a level held for several clocks
`timescale 1ns/1ps
module sync3 import buck_sup_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } sync_t;

    sync_t q, d;

    // a bit changes only once stages two and three agree
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int b = 0; b < W; b++) begin
            if (q.s2[b] == q.s3[b]) begin
                d.val[b] = q.s3[b];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.val;
endmodule : sync3

// ---- design/good_filter.sv ----
// per-channel good flag with fall deglitch and rise validation
// assumes synchronised comparator levels on the same clock
`timescale 1ns/1ps
module good_filter import buck_sup_pkg::*; #(
    parameter int VALID_CYC = PG_VALID_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic above,
    input  wire logic below,
    output logic      good,
    output logic      valid
);
    localparam logic [14:0] VALID_LAST = 15'(VALID_CYC - 1);
    localparam logic [9:0]  FALL_LAST  = 10'(PG_FALL_CYC);

    pgf_t q, d;

    // set above the high mark, clear after a long low spell
    always_comb begin
        d = q;
        if (above) begin
            d.good     = 1'b1;  // RULE17
            d.fall_cnt = '0;
        end else if (below && q.good) begin
            if (q.fall_cnt == FALL_LAST) begin
                d.good     = 1'b0;  // RULE17
                d.fall_cnt = '0;
            end else begin
                d.fall_cnt = q.fall_cnt + 10'h001;
            end
        end else begin
            d.fall_cnt = '0;
        end
        // validation restarts from zero on any drop
        if (!d.good) begin
            d.hold_cnt = '0;
            d.valid    = 1'b0;  // RULE19
        end else if (q.hold_cnt == VALID_LAST) begin
            d.valid = 1'b1;     // RULE19
        end else begin
            d.hold_cnt = q.hold_cnt + 15'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign good  = q.good;
    assign valid = q.valid;
endmodule : good_filter

// ---- sim/buck_sup_props.sv ----
// checker for the buck supervisor, bound to its ports
// assumes one clock and the asynchronous active-high reset
`timescale 1ns/1ps
module buck_sup_props import buck_sup_pkg::*; #(
    parameter int VALID_CYC = PG_VALID_CYC
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire ana_t        ana_raw,
    input wire bus_req_t    bus,
    input wire logic [31:0] rd_data,
    input wire logic [3:0]  hs_gate,
    input wire logic [3:0]  ls_gate,
    input wire logic [3:0]  soft_start_req,
    input wire logic        power_good_oe
);
    logic [15:0] up_q;
    logic [7:0]  gap_q;
    logic [7:0]  qlow_q;
    logic        hs_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ********************
    // time since reset, pulse gap, fold hold
    // ********************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            up_q   <= 16'h0;
            gap_q  <= 8'hFF;
            qlow_q <= 8'h0;
            hs_q   <= 1'b0;
        end else begin
            up_q   <= (up_q == 16'hFFFF) ? up_q : up_q + 16'h1;
            gap_q  <= (hs_gate[0] && !hs_q) ? 8'h0 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h1);
            qlow_q <= !ana_raw.fb_quarter_low[0] ? 8'h0
                    : ((qlow_q == 8'hFF) ? qlow_q : qlow_q + 8'h1);
            hs_q   <= hs_gate[0];
        end
    end
    no_overlap_a: assert property ((hs_gate & ls_gate) == 4'h0)
        else $error("both gates high");
    peak_cut_a: assert property (ana_raw.peak_limit[0] [*8] |-> !hs_gate[0])
        else $error("high side on at peak");
    hot_off_a: assert property (ana_raw.over_temp [*8] |-> (hs_gate | ls_gate) == 4'h0)
        else $error("gates on while hot");
    first_lock_a: assert property (ana_raw.supply_low_lockout[0] [*8] |-> hs_gate == 4'h0)
        else $error("runs in first lockout");
    own_lock_a: assert property (ana_raw.supply_low_lockout[1] [*8] |-> !hs_gate[1])
        else $error("runs in own lockout");
    enable_off_a: assert property (!ana_raw.channel_enable_pin[0] [*8] |-> !soft_start_req[0])
        else $error("soft start without enable");
    sync_wait_a: assert property ($rose(ana_raw.channel_enable_pin[0]) |-> !soft_start_req[0] [*3])
        else $error("enable not synchronised");
    pg_hold_a: assert property (up_q < VALID_CYC |-> power_good_oe)
        else $error("power good too early");
    fold_gap_a: assert property ($rose(hs_gate[0]) && qlow_q == 8'hFF |-> gap_q >= 8'h4F)
        else $error("quarter fold gap short");
    rd_idle_a: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
        else $error("stray read data");
    cover property ($rose(soft_start_req[0]));
    cover property ($fell(power_good_oe));
    cover property ($rose(ls_gate[0]));
endmodule : buck_sup_props
bind buck_fault_and_power_good_supervisor buck_sup_props #(.VALID_CYC(VALID_CYC)) i_buck_sup_props (
    .ref_clk(ref_clk), .rst(rst), .ana_raw(ana_raw), .bus(bus), .rd_data(rd_data),
    .hs_gate(hs_gate), .ls_gate(ls_gate), .soft_start_req(soft_start_req),
    .power_good_oe(power_good_oe));

// ---- sim/buck_stage_model.sv ----
// behavioural power stages: end of on time and peak current per channel
// assumes hs_gate levels from the supervisor on the same clock
`timescale 1ns/1ps
module buck_stage_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] hs_gate,
    input  wire logic [3:0] overload,
    output logic      [3:0] pwm_end,
    output logic      [3:0] peak_limit
);
    logic [3:0] hs_q = 4'h0;
    logic [3:0] age [4] = '{default: 4'hF};
    // age counts clocks since each high-side turn-on, saturating
    always @(posedge ref_clk) begin
        hs_q <= hs_gate;
        for (int k = 0; k < 4; k++) begin
            if (hs_gate[k] && !hs_q[k]) age[k] <= 4'h0;
            else if (age[k] != 4'hF) age[k] <= age[k] + 4'h1;
        end
    end
    // peak outlasts the reaction time, so the supervisor must cut the pulse
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            peak_limit[k] = overload[k] && age[k] >= 4'h1 && age[k] <= 4'h9;
            pwm_end[k]    = hs_gate[k] && age[k] >= 4'hA;
        end
    end
endmodule : buck_stage_model

// ---- sim/tb_buck_fault_and_power_good_supervisor.sv ----
// self-checking bench for the buck supervisor
// assumes short soft-start and validation counts
`timescale 1ns/1ps
module tb_buck_fault_and_power_good_supervisor import buck_sup_pkg::*;;
    localparam int SS = 100;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    ana_t        a = '0;
    ana_t        ana;
    bus_req_t    bus = '0;
    logic [31:0] rd_data, r;
    logic [3:0]  hs, ls, ssr, pe, pk, ovl = 4'h0;
    logic        pg_out, pg_oe, pg_in, pend = 1'b0;
    logic [31:0] eq [$];
    logic [31:0] mq [$];
    int          error_cnt = 0;
    int          n_tests = 0;
    always #25 ref_clk = ~ref_clk;
    assign pg_in = pg_oe ? pg_out : 1'b1; // pull-up when released
    always_comb begin
        ana = a;
        ana.pwm_end = pe;
        ana.peak_limit = pk;
    end
    buck_fault_and_power_good_supervisor #(.SS_CYC(SS), .VALID_CYC(20))
    i_buck_fault_and_power_good_supervisor (.ref_clk(ref_clk), .rst(rst), .ana_raw(ana),
        .bus(bus), .rd_data(rd_data), .hs_gate(hs), .ls_gate(ls), .soft_start_req(ssr),
        .power_good_in(pg_in), .power_good_out(pg_out), .power_good_oe(pg_oe));
    buck_stage_model i_buck_stage_model (.ref_clk(ref_clk), .hs_gate(hs), .overload(ovl),
        .pwm_end(pe), .peak_limit(pk));
    // ********************
    // tasks
    // ********************
    task wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt
    task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            error_cnt++;
            $display("Error %0t got %h exp %h", $time, g & m, e & m);
        end
    endtask : chk
    task wr(input logic [7:0] ad, input logic [31:0] d);
        bus <= '{ad, d, 1'b1, 1'b0};
        wt(1);
        bus.wr <= 1'b0;
        wt(1);
    endtask : wr
    task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        bus <= '{ad, 32'h0, 1'b0, 1'b1};
        eq.push_back(e);
        mq.push_back(m);
        wt(1);
        bus.rd <= 1'b0;
        wt(1);
    endtask : rd
    task cpg(input logic e);
        @(negedge ref_clk);
        chk({31'h0, pg_oe}, {31'h0, e}, 32'h1);
        wt(1);
    endtask : cpg
    task results;
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // read answers are compared mid-cycle, clear of the edges
    always @(negedge ref_clk) begin
        if (pend) chk(rd_data, eq.pop_front(), mq.pop_front());
        pend = bus.rd;
    end
    initial begin
        wt(40000);
        error_cnt++;
        results();
    end
    // ********************
    // main sequence
    // ********************
    initial begin
        void'($urandom(32'hE685));
        wt(5);
        rst <= 1'b0;
        wt(2);
        rd(CFG_ADDR, CFG_RESET, 32'hFFFFFFFF);
        rd(8'h08, 32'h0, 32'hFFFFFFFF);
        r = $urandom | 32'h10;
        wr(CFG_ADDR, r);
        rd(CFG_ADDR, r & CFG_MASK, 32'hFFFFFFFF);
        wr(CFG_ADDR, 32'h417);
        ovl <= 4'h1;
        a.channel_enable_pin <= 4'h3;
        wt(SS + 30);
        rd(STAT_ADDR, 32'h1000, 32'h1110);
        wt(380);
        rd(STAT_ADDR, 32'h100, 32'h1110);
        wt(64 * SS);
        rd(STAT_ADDR, 32'h10, 32'h1110);
        ovl <= 4'h0;
        a.channel_enable_pin[0] <= 1'b0;
        wt(20);
        a.channel_enable_pin[0] <= 1'b1;
        a.good_above[0] <= 1'b1;
        wt(SS + 40);
        rd(STAT_ADDR, 32'h21000, 32'h21010);
        cpg(1'b0);
        a.fb_quarter_low[0] <= 1'b1;
        a.max_duty <= 4'($urandom);
        wt(600);
        a.fb_quarter_low <= 4'h0;
        a.max_duty <= 4'h0;
        a.good_above[0] <= 1'b0;
        a.good_below[0] <= 1'b1;
        wt(900);
        cpg(1'b0);
        wt(200);
        cpg(1'b1);
        a.over_temp <= 1'b1;
        wt(10);
        rd(STAT_ADDR, 32'h10000, 32'h33000);
        a.over_temp <= 1'b0;
        wt(SS + 40);
        rd(STAT_ADDR, 32'h1000, 32'h3000);
        a.supply_low_lockout <= 4'h3;
        wt(10);
        rd(STAT_ADDR, 32'h40000, 32'h43000);
        a.supply_low_lockout <= 4'h0;
        wt(SS + 40);
        rd(STAT_ADDR, 32'h1000, 32'h3000);
        a.ov_trip[1] <= 1'b1;
        wt(10);
        rd(STAT_ADDR, 32'h1020, 32'h3020);
        results();
    end
endmodule : tb_buck_fault_and_power_good_supervisor
